// file: logic/dgcr_regs.sv
`timescale 1ns/1ps
`include "dgcr_defines.svh"
module dgcr_regs #(
    parameter int LOOP_DEPTH = 2,
    // revision value is arbitrary
    parameter logic [6:0] REVISION_CODE = 7'h2A
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic intAckStrobe,
    input wire logic intChannel,
    input wire dgcr_pkg::dgcr_kind_e intKind,
    output logic [7:0] intVector,
    input wire logic [7:0] rawIntStatus,
    input wire logic [1:0] txCharStrobe,
    input wire logic [1:0][7:0] txChar,
    input wire logic [1:0] retCharStrobe,
    input wire logic [1:0][7:0] retChar,
    input wire logic [1:0] retParityErr,
    input wire logic [1:0] retFrameErr,
    output logic [1:0] rxEnable,
    output logic [1:0] txEnable,
    output logic [1:0][7:0] modeCfg,
    output logic [1:0][7:0] clockSel,
    output logic [1:0] fifoSize256,
    output logic [1:0][2:0] rxIntLevel,
    output logic [1:0][1:0] txIntLevel,
    output logic [1:0] loopRouteEn,
    output logic [1:0] rxClkFromTxInv,
    output logic [1:0] loopErrIrq,
    output logic [7:0] gpioDir,
    output logic extendedMode,
    output logic div16Bypass
);
    localparam int AW = (LOOP_DEPTH > 1) ? $clog2(LOOP_DEPTH) : 1;
    localparam logic [AW:0] DEPTH_N = (AW+1)'(LOOP_DEPTH);

    ////////////////////////////////////////////////////////////////////
    // bus decode

    logic [6:0] regIdx;
    logic ackSet;
    logic wrFire;
    logic [1:0] ackCnt_q;
    logic [1:0] ackCnt_d;
    logic [1:0] ackTarget;
    logic [7:0] wrByte;

    assign regIdx = wb_adr_i[8:2];
    assign wrByte = wb_dat_i[7:0];

    function automatic logic isLegacy(input logic [6:0] idx);
        isLegacy = (idx <= `DGCR_LEGACY_TOP);
    endfunction

    // match index for channel a or channel b; returns {hit, channel}
    function automatic logic [1:0] chanHit(input logic [6:0] idx,
                                           input logic [6:0] base);
        if (idx == base) begin
            chanHit = 2'h2;
        end else if (idx == base + `DGCR_CH_STRIDE) begin
            chanHit = 2'h3;
        end else begin
            chanHit = 2'h0;
        end
    endfunction

    logic [7:0] globalCfg_q;
    dgcr_pkg::dgcr_vec_e vecMode;

    assign vecMode = dgcr_pkg::dgcr_vec_e'(
        globalCfg_q[`DGCR_GC_VEC_HI:`DGCR_GC_VEC_LO]);

    always_comb begin
        unique case (globalCfg_q[`DGCR_GC_ACK_HI:`DGCR_GC_ACK_LO])
            2'h0: ackTarget = `DGCR_ACK_CYC_00;
            2'h1: ackTarget = `DGCR_ACK_CYC_01;
            2'h2: ackTarget = `DGCR_ACK_CYC_10;
            2'h3: ackTarget = `DGCR_ACK_CYC_00;
        endcase
    end

    assign ackSet = wb_cyc_i && wb_stb_i && !wb_ack_o &&
                    (ackCnt_q == ackTarget - 2'd1);
    assign wrFire = ackSet && wb_we_i && wb_sel_i[0];

    always_comb begin
        ackCnt_d = ackCnt_q;
        if (!(wb_cyc_i && wb_stb_i) || wb_ack_o || ackSet) begin
            ackCnt_d = 2'd0;
        end else begin
            ackCnt_d = ackCnt_q + 2'd1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ackCnt_q <= 2'd0;
            wb_ack_o <= 1'b0;
        end else begin
            ackCnt_q <= ackCnt_d;
            wb_ack_o <= ackSet;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // legacy command decode

    logic [1:0] cmdHit;
    logic legacyReset;
    logic enableAll;

    assign cmdHit = chanHit(regIdx, `DGCR_IDX_CMD);
    assign legacyReset = wrFire && cmdHit[1] &&
                         (wrByte == `DGCR_CMD_LEGACY_RESET);
    assign enableAll = wrFire && cmdHit[1] &&
                       (wrByte == `DGCR_CMD_ENABLE_ALL);

    // extended features switch on with any access above legacy range
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            extendedMode <= 1'b0;
        end else if (legacyReset) begin
            extendedMode <= 1'b0;
        end else if (ackSet && !isLegacy(regIdx)) begin
            extendedMode <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // per channel control registers

    logic [1:0][7:0] mr0_q;
    logic [1:0][7:0] sfeat_q;
    logic [1:0] loopErrSet;

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : gChan
            logic chHitMode;
            logic chHitClk;
            logic chHitCmd;
            logic chHitMr0;
            logic chHitSf;

            assign chHitMode =
                chanHit(regIdx, `DGCR_IDX_MODE) == {1'b1, 1'(ch)};
            assign chHitClk =
                chanHit(regIdx, `DGCR_IDX_CLKSEL) == {1'b1, 1'(ch)};
            assign chHitCmd = cmdHit == {1'b1, 1'(ch)};
            assign chHitMr0 =
                chanHit(regIdx, `DGCR_IDX_MR0) == {1'b1, 1'(ch)};
            assign chHitSf =
                chanHit(regIdx, `DGCR_IDX_SFEAT) == {1'b1, 1'(ch)};

            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    modeCfg[ch] <= `DGCR_MODE_RESET;
                    clockSel[ch] <= `DGCR_CLKSEL_9600;
                end else if (legacyReset) begin
                    modeCfg[ch] <= `DGCR_MODE_RESET;
                    clockSel[ch] <= `DGCR_CLKSEL_9600;
                end else if (wrFire && chHitMode) begin
                    modeCfg[ch] <= wrByte;
                end else if (wrFire && chHitClk) begin
                    clockSel[ch] <= wrByte;
                end
            end

            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    rxEnable[ch] <= 1'b0;
                    txEnable[ch] <= 1'b0;
                end else if (legacyReset) begin
                    rxEnable[ch] <= 1'b0;
                    txEnable[ch] <= 1'b0;
                end else if (enableAll && chHitCmd) begin
                    rxEnable[ch] <= 1'b1;
                    txEnable[ch] <= 1'b1;
                end else if (wrFire && chHitCmd) begin
                    if (wrByte[`DGCR_CMD_RX_OFF]) begin
                        rxEnable[ch] <= 1'b0;
                    end else if (wrByte[`DGCR_CMD_RX_ON]) begin
                        rxEnable[ch] <= 1'b1;
                    end
                    if (wrByte[`DGCR_CMD_TX_OFF]) begin
                        txEnable[ch] <= 1'b0;
                    end else if (wrByte[`DGCR_CMD_TX_ON]) begin
                        txEnable[ch] <= 1'b1;
                    end
                end
            end

            // zero gives 8-byte fifo, rx on ready, tx on empty
            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    mr0_q[ch] <= `DGCR_ZERO_RESET;
                end else if (legacyReset) begin
                    mr0_q[ch] <= `DGCR_ZERO_RESET;
                end else if (wrFire && chHitMr0) begin
                    mr0_q[ch] <= wrByte & `DGCR_MR0_WMASK;
                end
            end

            assign fifoSize256[ch] = mr0_q[ch][`DGCR_MR0_FIFO256];
            assign rxIntLevel[ch] = {fifoSize256[ch],
                                     mr0_q[ch][`DGCR_MR0_RXLVL],
                                     modeCfg[ch][`DGCR_MODE_RXLVL]};
            assign txIntLevel[ch] =
                mr0_q[ch][`DGCR_MR0_TXLVL_HI:`DGCR_MR0_TXLVL_LO];

            // error flag: hardware set wins over a write-one clear
            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    sfeat_q[ch] <= `DGCR_ZERO_RESET;
                end else begin
                    if (wrFire && chHitSf) begin
                        sfeat_q[ch][`DGCR_SF_CHK_HI:`DGCR_SF_CHK_LO] <=
                            wrByte[`DGCR_SF_CHK_HI:`DGCR_SF_CHK_LO];
                    end
                    if (loopErrSet[ch]) begin
                        sfeat_q[ch][`DGCR_SF_ERR] <= 1'b1;
                    end else if (wrFire && chHitSf &&
                                 wrByte[`DGCR_SF_ERR]) begin
                        sfeat_q[ch][`DGCR_SF_ERR] <= 1'b0;
                    end
                end
            end

            //////////////////////////////////////////////////////////
            // returned data checker

            dgcr_pkg::dgcr_chk_e chkMode;
            logic chkOn;
            logic [AW-1:0] wrPtr_q;
            logic [AW-1:0] rdPtr_q;
            logic [AW:0] fill_q;
            logic [7:0] headChar;
            logic push;
            logic pop;
            logic errEvt;

            assign chkMode = dgcr_pkg::dgcr_chk_e'(
                sfeat_q[ch][`DGCR_SF_CHK_HI:`DGCR_SF_CHK_LO]);
            assign chkOn = (chkMode == dgcr_pkg::DGCR_CHK_TXC) ||
                           (chkMode == dgcr_pkg::DGCR_CHK_TXC_INV);
            assign loopRouteEn[ch] = chkOn;
            assign rxClkFromTxInv[ch] =
                chkMode == dgcr_pkg::DGCR_CHK_TXC_INV;
            assign loopErrIrq[ch] = sfeat_q[ch][`DGCR_SF_ERR];

            assign push = chkOn && txCharStrobe[ch] && (fill_q != DEPTH_N);
            assign pop = chkOn && retCharStrobe[ch] && (fill_q != '0);

            // late echo, unexpected echo, mismatch or bad returned frame
            assign errEvt = chkOn && (
                (txCharStrobe[ch] && (fill_q == DEPTH_N)) ||
                (retCharStrobe[ch] && (fill_q == '0)) ||
                (pop && (headChar != retChar[ch])) ||
                (retCharStrobe[ch] &&
                 (retParityErr[ch] || retFrameErr[ch])));
            assign loopErrSet[ch] = errEvt;

            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    wrPtr_q <= '0;
                    rdPtr_q <= '0;
                    fill_q <= '0;
                end else if (!chkOn) begin
                    wrPtr_q <= '0;
                    rdPtr_q <= '0;
                    fill_q <= '0;
                end else begin
                    if (push) begin
                        wrPtr_q <= (wrPtr_q == AW'(LOOP_DEPTH - 1)) ?
                                   '0 : wrPtr_q + 1'b1;
                    end
                    if (pop) begin
                        rdPtr_q <= (rdPtr_q == AW'(LOOP_DEPTH - 1)) ?
                                   '0 : rdPtr_q + 1'b1;
                    end
                    fill_q <= fill_q + (AW+1)'(push) - (AW+1)'(pop);
                end
            end

            dgcr_loop_mem #(
                .WIDTH(8),
                .DEPTH(LOOP_DEPTH),
                .AW(AW)
            ) uLoopMem (
                .sys_clk(sys_clk),
                .rst_n(rst_n),
                .wrEn(push),
                .wrAddr(wrPtr_q),
                .wrData(txChar[ch]),
                .rdAddr(pop ? ((rdPtr_q == AW'(LOOP_DEPTH - 1)) ?
                               AW'(0) : rdPtr_q + 1'b1) : rdPtr_q),
                .rdData_q(headChar)
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // global registers

    logic [7:0] intMask_q;
    logic [7:0] vectorReg_q;
    logic [7:0] testBits_q;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            globalCfg_q <= `DGCR_ZERO_RESET;
        end else if (wrFire && regIdx == `DGCR_IDX_GCONFIG) begin
            globalCfg_q <= wrByte & `DGCR_GC_WMASK;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            intMask_q <= `DGCR_ZERO_RESET;
        end else if (wrFire && regIdx == `DGCR_IDX_INTSTAT) begin
            intMask_q <= wrByte;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            vectorReg_q <= `DGCR_ZERO_RESET;
        end else if (wrFire && regIdx == `DGCR_IDX_VECTOR) begin
            vectorReg_q <= wrByte;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            gpioDir <= `DGCR_ZERO_RESET;
        end else if (legacyReset) begin
            gpioDir <= `DGCR_ZERO_RESET;
        end else if (wrFire && regIdx == `DGCR_IDX_GPIODIR) begin
            gpioDir <= wrByte;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            testBits_q <= `DGCR_ZERO_RESET;
        end else if (wrFire && regIdx == `DGCR_IDX_TESTREV) begin
            testBits_q <= {wrByte[`DGCR_TR_BYPASS], 7'h00};
        end
    end

    assign div16Bypass = testBits_q[`DGCR_TR_BYPASS];

    ////////////////////////////////////////////////////////////////////
    // interrupt acknowledge vector

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            intVector <= 8'hFF;
        end else if (intAckStrobe) begin
            unique case (vecMode)
                dgcr_pkg::DGCR_VEC_NONE:
                    intVector <= 8'hFF;
                dgcr_pkg::DGCR_VEC_PLAIN:
                    intVector <= vectorReg_q;
                dgcr_pkg::DGCR_VEC_CHAN:
                    intVector <= {vectorReg_q[7:1], intChannel};
                dgcr_pkg::DGCR_VEC_FULL:
                    intVector <= {vectorReg_q[7:3], intKind,
                                  intChannel};
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read path

    logic [7:0] rdByte;
    logic [1:0] rdHit;

    always_comb begin
        rdByte = 8'h00;
        rdHit = 2'h0;
        if (regIdx == `DGCR_IDX_INTSTAT) begin
            rdByte = globalCfg_q[`DGCR_GC_MASKRD] ?
                     (rawIntStatus & intMask_q) : rawIntStatus;
        end else if (regIdx == `DGCR_IDX_VECTOR) begin
            rdByte = vectorReg_q;
        end else if (regIdx == `DGCR_IDX_GCONFIG) begin
            rdByte = globalCfg_q;
        end else if (regIdx == `DGCR_IDX_GPIODIR) begin
            rdByte = gpioDir;
        end else if (regIdx == `DGCR_IDX_STATUS) begin
            rdByte = {3'h0, extendedMode, txEnable, rxEnable};
        end else if (regIdx == `DGCR_IDX_TESTREV) begin
            rdByte = {testBits_q[`DGCR_TR_BYPASS], REVISION_CODE};
        end else begin
            rdHit = chanHit(regIdx, `DGCR_IDX_MODE);
            if (rdHit[1]) begin
                rdByte = modeCfg[rdHit[0]];
            end
            rdHit = chanHit(regIdx, `DGCR_IDX_CLKSEL);
            if (rdHit[1]) begin
                rdByte = clockSel[rdHit[0]];
            end
            rdHit = chanHit(regIdx, `DGCR_IDX_MR0);
            if (rdHit[1]) begin
                rdByte = mr0_q[rdHit[0]];
            end
            rdHit = chanHit(regIdx, `DGCR_IDX_SFEAT);
            if (rdHit[1]) begin
                rdByte = sfeat_q[rdHit[0]];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_dat_o <= 32'h00000000;
        end else if (ackSet) begin
            wb_dat_o <= {24'h000000, wb_we_i ? 8'h00 : rdByte};
        end
    end
endmodule

// file: pkg/dgcr_defines.svh
`ifndef DGCR_DEFINES_SVH
`define DGCR_DEFINES_SVH

// register indices; byte address is four times the index
`define DGCR_IDX_MODE 7'h00
`define DGCR_IDX_CLKSEL 7'h01
`define DGCR_IDX_CMD 7'h02
`define DGCR_IDX_INTSTAT 7'h05
`define DGCR_IDX_VECTOR 7'h0C
`define DGCR_IDX_MR0 7'h20
`define DGCR_IDX_GCONFIG 7'h40
`define DGCR_IDX_SFEAT 7'h41
`define DGCR_IDX_GPIODIR 7'h42
`define DGCR_IDX_STATUS 7'h43
`define DGCR_IDX_TESTREV 7'h4F
`define DGCR_CH_STRIDE 7'h08
`define DGCR_LEGACY_TOP 7'h0F

// reset values
`define DGCR_MODE_RESET 8'h13
`define DGCR_CLKSEL_9600 8'hBB
`define DGCR_ZERO_RESET 8'h00

// command codes
`define DGCR_CMD_ENABLE_ALL 8'hE0
`define DGCR_CMD_LEGACY_RESET 8'hC0
`define DGCR_CMD_RX_ON 0
`define DGCR_CMD_RX_OFF 1
`define DGCR_CMD_TX_ON 2
`define DGCR_CMD_TX_OFF 3

// field positions
`define DGCR_GC_ACK_HI 7
`define DGCR_GC_ACK_LO 6
`define DGCR_GC_VEC_HI 2
`define DGCR_GC_VEC_LO 1
`define DGCR_GC_MASKRD 0
`define DGCR_SF_ERR 3
`define DGCR_SF_CHK_HI 2
`define DGCR_SF_CHK_LO 1
`define DGCR_TR_BYPASS 7
`define DGCR_MR0_FIFO256 3
`define DGCR_MR0_RXLVL 6
`define DGCR_MR0_TXLVL_HI 5
`define DGCR_MR0_TXLVL_LO 4
`define DGCR_MODE_RXLVL 6

// writable masks
`define DGCR_GC_WMASK 8'hC7
`define DGCR_SF_WMASK 8'h06
`define DGCR_MR0_WMASK 8'h7D

// data ack delays in system clocks per code
`define DGCR_ACK_CYC_00 2'd3
`define DGCR_ACK_CYC_01 2'd2
`define DGCR_ACK_CYC_10 2'd1

`endif

// file: pkg/dgcr_pkg.sv
package dgcr_pkg;
    // kind of the source that won interrupt arbitration
    typedef enum logic [1:0] {
        DGCR_KIND_OTHER = 2'h0,
        DGCR_KIND_TX = 2'h1,
        DGCR_KIND_RX = 2'h2,
        DGCR_KIND_RX_ERR = 2'h3
    } dgcr_kind_e;

    typedef enum logic [1:0] {
        DGCR_VEC_NONE = 2'h0,
        DGCR_VEC_PLAIN = 2'h1,
        DGCR_VEC_CHAN = 2'h2,
        DGCR_VEC_FULL = 2'h3
    } dgcr_vec_e;

    typedef enum logic [1:0] {
        DGCR_CHK_OFF = 2'h0,
        DGCR_CHK_TXC = 2'h1,
        DGCR_CHK_TXC_INV = 2'h2,
        DGCR_CHK_RSVD = 2'h3
    } dgcr_chk_e;
endpackage

// file: logic/dgcr_loop_mem.sv
`timescale 1ns/1ps
module dgcr_loop_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4,
    parameter int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic wrEn,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [WIDTH-1:0] wrData,
    input wire logic [AW-1:0] rdAddr,
    output logic [WIDTH-1:0] rdData_q
);
    logic [WIDTH-1:0] store [DEPTH];

    always_ff @(posedge sys_clk) begin
        if (wrEn) begin
            store[wrAddr] <= wrData;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdData_q <= '0;
        end else begin
            rdData_q <= store[rdAddr];
        end
    end
endmodule

// file: dv/dgcr_regs_chk.sv
`timescale 1ns/1ps
module dgcr_regs_chk #(
    parameter int LOOP_DEPTH = 2
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic intAckStrobe,
    input wire logic [7:0] intVector,
    input wire logic [1:0] txCharStrobe,
    input wire logic [1:0] retCharStrobe,
    input wire logic [1:0] loopRouteEn,
    input wire logic [1:0] rxClkFromTxInv,
    input wire logic [1:0] loopErrIrq,
    input wire logic [1:0] fifoSize256,
    input wire logic [1:0][2:0] rxIntLevel,
    input wire logic [7:0] gpioDir,
    input wire logic extendedMode,
    input wire logic div16Bypass
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic req;
    assign req = wb_cyc_i & wb_stb_i;
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_bound: assert property ($rose(req) |-> ##[1:3] wb_ack_o)
        else $error("ack later than three cycles");
    a_ack_cause: assert property (wb_ack_o |-> req)
        else $error("ack without a request");
    a_vec_hold: assert property (!$past(intAckStrobe) |->
        $stable(intVector))
        else $error("vector moved without acknowledge");
    a_ext_cause: assert property ($rose(extendedMode) |->
        wb_ack_o && wb_adr_i[8:2] > 7'h0F)
        else $error("extended mode without high access");
    a_inv_route: assert property ($rose(wb_ack_o) && wb_we_i && wb_sel_i[0]
        && wb_adr_i[8:2] == 7'h41 |-> rxClkFromTxInv[0] ==
        (wb_dat_i[2:1] == 2'h2) && loopRouteEn[0] == ^wb_dat_i[2:1])
        else $error("check mode not applied");
    a_legacy_clr: assert property ($rose(wb_ack_o) && wb_we_i && wb_sel_i[0]
        && wb_dat_i[7:0] == 8'hC0 && wb_adr_i[8:2] == 7'h02 |->
        fifoSize256 == 2'h0 && gpioDir == 8'h00 && !extendedMode
        && rxIntLevel[0] == 3'h0)
        else $error("legacy reset left state behind");
    a_err_clear: assert property ($rose(wb_ack_o) && wb_we_i && wb_sel_i[0]
        && wb_dat_i[3] && wb_adr_i[8:2] == 7'h41
        && !$past(retCharStrobe[0] | txCharStrobe[0])
        |-> !loopErrIrq[0])
        else $error("error flag not cleared");
    a_err_cause: assert property ($rose(loopErrIrq[0]) |->
        $past(retCharStrobe[0] | txCharStrobe[0]))
        else $error("error flag without a character");
    a_dir_write: assert property ($changed(gpioDir) |->
        wb_ack_o && wb_we_i)
        else $error("port direction moved without write");
    a_bypass_wr: assert property ($changed(div16Bypass) |->
        wb_ack_o && wb_we_i && wb_adr_i[8:2] == 7'h4F)
        else $error("bypass moved without write");
    cover property ($rose(extendedMode));
    cover property ($rose(loopErrIrq[0]));
    cover property (intAckStrobe ##1 !intAckStrobe);
endmodule
bind dgcr_regs dgcr_regs_chk #(.LOOP_DEPTH(LOOP_DEPTH)) chk (.*);

// file: dv/dgcr_host.sv
`timescale 1ns/1ps
module dgcr_host (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic go,
    input wire logic goWe,
    input wire logic [6:0] goIdx,
    input wire logic [7:0] goDat,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    output logic wb_cyc_i,
    output logic wb_stb_i,
    output logic wb_we_i,
    output logic [31:0] wb_adr_i,
    output logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_i,
    output logic done,
    output logic [7:0] rdat
);
    // request held until ack, so any ack delay covers the strobe width
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
            wb_we_i <= 1'b0;
            wb_adr_i <= 32'h0;
            wb_sel_i <= 4'h0;
            wb_dat_i <= 32'h0;
            done <= 1'b0;
            rdat <= 8'h00;
        end else if (wb_cyc_i && wb_ack_o) begin
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
            // released address and data lines must not keep showing the old value
            wb_adr_i <= ~wb_adr_i;
            wb_dat_i <= ~wb_dat_i;
            rdat <= wb_dat_o[7:0];
            done <= 1'b1;
        end else begin
            done <= 1'b0;
            if (go && !wb_cyc_i && !done) begin
                wb_cyc_i <= 1'b1;
                wb_stb_i <= 1'b1;
                wb_we_i <= goWe;
                wb_adr_i <= {23'h0, goIdx, 2'h0};
                wb_sel_i <= 4'hF;
                wb_dat_i <= {24'h0, goDat};
            end
        end
    end
endmodule

// file: dv/tb_dgcr_regs.sv
`timescale 1ns/1ps
module tb_dgcr_regs;
    // revision value is arbitrary
    localparam logic [6:0] REV = 7'h2A;
    localparam logic [23:0] ROWS [11] = '{
        {1'b0, 7'h00, 8'h00, 8'h13},
        {1'b0, 7'h01, 8'h00, 8'hBB},
        {1'b0, 7'h0C, 8'h00, 8'h00},
        {1'b0, 7'h20, 8'h00, 8'h00},
        {1'b1, 7'h4F, 8'hFF, 8'h00},
        {1'b0, 7'h4F, 8'h00, {1'b1, REV}},
        {1'b1, 7'h40, 8'hFF, 8'h00},
        {1'b0, 7'h40, 8'h00, 8'hC7},
        {1'b1, 7'h41, 8'hFF, 8'h00},
        {1'b0, 7'h41, 8'h00, 8'h06},
        {1'b0, 7'h30, 8'h00, 8'h00}};
    logic sys_clk = 1'b0, rst_n = 1'b1;
    logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, done, extendedMode;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o;
    logic intAckStrobe = 1'b0, intChannel = 1'b0, div16Bypass;
    dgcr_pkg::dgcr_kind_e intKind = dgcr_pkg::DGCR_KIND_OTHER;
    logic [7:0] intVector, gpioDir, rdat, rawIntStatus = 8'h00;
    logic [1:0] txCharStrobe = 2'h0, retCharStrobe = 2'h0;
    logic [1:0] retParityErr = 2'h0, retFrameErr = 2'h0;
    logic [1:0] rxEnable, txEnable, fifoSize256, loopRouteEn;
    logic [1:0] rxClkFromTxInv, loopErrIrq;
    logic [1:0][7:0] txChar = 16'h0, retChar = 16'h0, modeCfg, clockSel;
    logic [1:0][2:0] rxIntLevel;
    logic [1:0][1:0] txIntLevel;
    logic go = 1'b0, goWe = 1'b0;
    logic [6:0] goIdx = 7'h00;
    logic [7:0] goDat = 8'h00;
    int error_cnt = 0, cmp_count = 0;
    always #10 sys_clk = ~sys_clk;
    dgcr_regs #(.REVISION_CODE(REV)) uut (.*);
    dgcr_host host (.*);
////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic xfer(input logic w, input logic [6:0] i,
                        input logic [7:0] d);
        @(posedge sys_clk);
        go <= 1'b1;
        goWe <= w;
        goIdx <= i;
        goDat <= d;
        @(posedge sys_clk);
        go <= 1'b0;
        do @(negedge sys_clk); while (done !== 1'b1);
    endtask
    // far end returns character r a few cycles after character s is sent
    task automatic loopChar(input logic [7:0] s, r, input logic [1:0] e);
        @(posedge sys_clk);
        txChar[0] <= s;
        txCharStrobe <= 2'h1;
        @(posedge sys_clk);
        txCharStrobe <= 2'h0;
        repeat (2) @(posedge sys_clk);
        retChar[0] <= r;
        retCharStrobe <= 2'h1;
        retParityErr <= {1'b0, e[0]};
        retFrameErr <= {1'b0, e[1]};
        @(posedge sys_clk);
        retCharStrobe <= 2'h0;
        retChar[0] <= ~r;
        repeat (2) @(negedge sys_clk);
    endtask
////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n <= 1'b0;
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        foreach (ROWS[k]) begin
            xfer(ROWS[k][23], ROWS[k][22:16], ROWS[k][15:8]);
            if (!ROWS[k][23]) check(rdat, ROWS[k][7:0]);
        end
        check({extendedMode, div16Bypass}, 8'h03);
        xfer(1'b1, 7'h42, 8'hFF);
        xfer(1'b1, 7'h20, 8'h08);
        check({gpioDir[0], fifoSize256[0]}, 8'h03);
        xfer(1'b1, 7'h02, 8'hC0);
        check(gpioDir | {6'h00, fifoSize256[0], extendedMode}, 8'h00);
        xfer(1'b1, 7'h0A, 8'hE0);
        check({txEnable, rxEnable}, 8'h0A);
        xfer(1'b1, 7'h40, 8'h40);
        xfer(1'b1, 7'h0C, 8'hA4);
        xfer(1'b1, 7'h05, 8'h0F);
        @(posedge sys_clk);
        rawIntStatus <= 8'h5A;
        intChannel <= 1'b1;
        intKind <= dgcr_pkg::DGCR_KIND_RX_ERR;
        for (int m = 0; m < 4; m++) begin
            xfer(1'b1, 7'h40, {5'h10, m[1:0], m[0]});
            xfer(1'b0, 7'h05, 8'h00);
            check(rdat, m[0] ? 8'h0A : 8'h5A);
            @(posedge sys_clk);
            intAckStrobe <= 1'b1;
            @(posedge sys_clk);
            intAckStrobe <= 1'b0;
            @(negedge sys_clk);
            check(intVector, m == 0 ? 8'hFF : m == 1 ? 8'hA4 :
                m == 2 ? 8'hA5 : 8'hA7);
        end
        xfer(1'b1, 7'h41, 8'h04);
        check({rxClkFromTxInv[0], loopRouteEn[0]}, 8'h03);
        xfer(1'b1, 7'h41, 8'h02);
        check({rxClkFromTxInv[0], loopRouteEn[0]}, 8'h01);
        loopChar(8'h55, 8'h55, 2'h0);
        check(loopErrIrq[0], 8'h00);
        for (int e = 0; e < 3; e++) begin
            loopChar(8'h33, e == 0 ? 8'h32 : 8'h33, e[1:0]);
            check(loopErrIrq[0], 8'h01);
            xfer(1'b1, 7'h41, 8'h02);
            check(loopErrIrq[0], 8'h01);
            xfer(1'b1, 7'h41, 8'h0A);
            check(loopErrIrq[0], 8'h00);
        end
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(negedge sys_clk);
        check({rxEnable, txEnable, div16Bypass, extendedMode}, 8'h00);
        check(clockSel[0], 8'hBB);
        check(modeCfg[0], 8'h13);
        check(intVector, 8'hFF);
        check({rxIntLevel[0], txIntLevel[0]}, 8'h00);
        tally_and_finish();
    end
    initial begin
        repeat (4000) @(posedge sys_clk);
        error_cnt++;
        tally_and_finish();
    end
endmodule
